// file: common/sdicr_regs.vh
// Constants of the SDI-12 sensor command responder.
// Assumes a 250 MHz core clock and a one-second tick from the real-time clock.
`ifndef SDICR_REGS_VH
`define SDICR_REGS_VH

// Bus characters
`define SDICR_CH_BANG      8'h21
`define SDICR_CH_QUERY     8'h3F
`define SDICR_CH_CR        8'h0D
`define SDICR_CH_LF        8'h0A
`define SDICR_CH_ZERO      8'h30
// Address after reset until the stored address is taken in
`define SDICR_ADDR_RST     8'h30
// Protocol level reported in the identification reply
`define SDICR_LEVEL_TXT    16'h3134
// Measurement timing and value count
`define SDICR_MEAS_TIME_S  10'h014
`define SDICR_NUM_VALUES   4'h6
`define SDICR_HIST_VALUES  4'h8
`define SDICR_VAL_CHARS    4'h8
// Reading interval settings, in minutes
`define SDICR_IVL_MIN      10'h001
`define SDICR_IVL_MAX      10'h2D0
`define SDICR_IVL_RST      10'h03C
`define SDICR_SCHED_RST    1'b1
`define SDICR_SEC_PER_MIN  16'h003C
// Reply CRC
`define SDICR_CRC_POLY     16'hA001
`define SDICR_CRC_INIT     16'h0000
`define SDICR_CRC_CHAR     8'h40

`endif

// file: rtl/sdicr_crc.v
// One-byte step of the reflected 16-bit reply checksum.
// Purely combinational; the caller holds the running value.
`timescale 1ns/100ps
`include "sdicr_regs.vh"

module sdicr_crc (
    input  wire [15:0] crc_in,   // Running checksum
    input  wire [7:0]  data_in,  // Byte to fold in
    output reg  [15:0] crc_out   // Checksum after the byte
);
    integer i;

    // Fold the byte in, least significant bit first
    always @* begin
        crc_out = crc_in ^ {8'h00, data_in};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `SDICR_CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end
endmodule

// file: rtl/sdicr_dec.v
// Binary to three ASCII decimal digits, for values up to 999.
// Purely combinational.
`timescale 1ns/100ps
`include "sdicr_regs.vh"

module sdicr_dec (
    input  wire [9:0] bin_in,   // Value to print
    output wire [7:0] hun_ch,   // Hundreds digit
    output wire [7:0] ten_ch,   // Tens digit
    output wire [7:0] one_ch    // Units digit
);
    // Split by constant division
    wire [9:0] hun_w = bin_in / 10'h064;
    wire [9:0] ten_w = (bin_in / 10'h00A) % 10'h00A;
    wire [9:0] one_w = bin_in % 10'h00A;

    assign hun_ch = `SDICR_CH_ZERO + {4'h0, hun_w[3:0]};
    assign ten_ch = `SDICR_CH_ZERO + {4'h0, ten_w[3:0]};
    assign one_ch = `SDICR_CH_ZERO + {4'h0, one_w[3:0]};
endmodule

// file: rtl/sdicr_top.v
// SDI-12 sensor command responder: parses recorder commands byte by byte
// and streams replies, runs the reading schedule and steers measurements.
// Assumes a physical layer that delivers command bytes and takes reply bytes,
// an external measurement engine, history store, clock and address store.
`timescale 1ns/100ps
`include "sdicr_regs.vh"

module sdicr_top #(
    parameter [63:0]  VENDOR_TXT = "VENDOR01",          // Arbitrary vendor name
    parameter [47:0]  MODEL_TXT  = "MODEL1",            // Arbitrary model name
    parameter [127:0] FW_TXT     = "1.0.0-0-g0000000"   // Arbitrary version text
) (
    input  wire         core_clk,       // 250 MHz clock
    input  wire         rst,            // Synchronous reset, active high
    input  wire         rx_valid,       // Command byte strobe
    input  wire [7:0]   rx_data,        // Command byte
    output wire         tx_valid,       // Reply byte valid
    output wire [7:0]   tx_data,        // Reply byte
    input  wire         tx_ready,       // Physical layer takes reply byte
    input  wire [7:0]   boot_addr,      // Stored address, taken after reset
    output wire         addr_store,     // Pulse: store new address
    output wire [7:0]   cur_addr,       // Address in effect
    input  wire [103:0] serial_txt,     // Serial number, 13 chars, first high
    input  wire [55:0]  rtc_bcd,        // YYYYMMDDhhmmss digits, first high
    input  wire         sec_tick,       // One pulse per second
    output wire         meas_start,     // Pulse: begin a measurement
    input  wire         meas_done,      // Pulse: measurement stored
    output wire         meas_busy,      // Measurement running
    input  wire [3:0]   hist_count,     // Readings held in history
    output wire [3:0]   val_hist,       // History index read, 0 newest
    output wire [2:0]   val_idx,        // Value index read
    output wire [2:0]   val_pos,        // Character index read
    input  wire [7:0]   val_char,       // Character, 0 after end of text
    output wire [9:0]   ivl_min,        // Reading interval in minutes
    output wire         sched_en        // Scheduled readings enabled
);
    // Send states
    localparam [2:0] S_IDLE = 3'h0, S_ADDR = 3'h1, S_BODY = 3'h2, S_CRC = 3'h3,
                     S_CR = 3'h4, S_LF = 3'h5;
    // Reply bodies
    localparam [3:0] J_NONE = 4'h0, J_IDENT = 4'h1, J_MTIME = 4'h2, J_DATA = 4'h3,
                     J_HIST = 4'h4, J_PARM = 4'h5, J_SETV = 4'h6, J_CLOCK = 4'h7,
                     J_FW = 4'h8;

    reg  [2:0]  st_r;
    reg  [3:0]  job_r;
    reg  [6:0]  j_r;
    reg         crc_on_r;
    reg         two_r;
    reg  [3:0]  hist_r;
    reg  [3:0]  pidx_r;
    reg         ssel_r;
    reg  [15:0] crc_r;
    reg  [1:0]  crci_r;
    reg  [7:0]  tx_data_r;
    reg         tx_valid_r;
    reg  [7:0]  addr_r;
    reg         boot_r;
    reg         nv_wr_r;
    reg  [9:0]  ivl_r;
    reg         sched_r;
    reg  [15:0] sec_cnt_r;
    reg  [9:0]  min_cnt_r;
    reg         mstart_r;
    reg         busy_r;
    reg         srq_arm_r;
    reg         srq_pend_r;
    reg         mcrc_r;
    reg  [7:0]  cb [0:7];
    reg  [3:0]  len_r;
    reg  [7:0]  bch;
    reg  [6:0]  blen;
    reg  [9:0]  xval;
    reg         xok;
    integer     k;

    wire        go     = (st_r == S_IDLE) && rx_valid && (rx_data == `SDICR_CH_BANG);
    wire        own    = (len_r != 4'h0) && (cb[0] == addr_r);
    wire        can_ld = !tx_valid_r || tx_ready;
    wire        c3     = (len_r > 4'h3) && (cb[3] == "C");
    wire [3:0]  pp     = c3 ? 4'h4 : 4'h3;
    wire [7:0]  pch    = cb[pp[2:0] + 3'h3];
    wire [7:0]  d2, d1, d0;
    wire [15:0] crc_nx;
    wire [9:0]  dec_in = (job_r != J_SETV) ? `SDICR_MEAS_TIME_S :
                         (ssel_r ? {9'h000, sched_r} : ivl_r);
    wire        nan    = (job_r == J_HIST) && (hist_r >= hist_count);
    wire [3:0]  cki    = (j_r < 7'h04) ? j_r[3:0] : (j_r < 7'h07) ? j_r[3:0] - 4'h1 :
                         (j_r < 7'h0A) ? j_r[3:0] - 4'h2 : (j_r < 7'h0D) ? j_r[3:0] - 4'h3 :
                         (j_r < 7'h10) ? j_r[3:0] - 4'h4 : j_r[3:0] - 4'h5;

    sdicr_dec u_dec (
        .bin_in (dec_in),
        .hun_ch (d2),
        .ten_ch (d1),
        .one_ch (d0)
    );

    sdicr_crc u_crc (
        .crc_in  (crc_r),
        .data_in ((st_r == S_ADDR) ? addr_r : bch),
        .crc_out (crc_nx)
    );

    // Parameter identifiers, padded with zero bytes
    function [31:0] pid_txt;
        input [3:0] i;
        case (i)
            4'h1:    pid_txt = "VBAT";
            4'h2:    pid_txt = "TEMP";
            4'h3:    pid_txt = {"220", 8'h00};
            4'h4:    pid_txt = {"270", 8'h00};
            4'h5:    pid_txt = {"PPM", 8'h00};
            default: pid_txt = "FAIL";
        endcase
    endfunction

    // Parameter units, padded with zero bytes
    function [23:0] punit_txt;
        input [3:0] i;
        case (i)
            4'h1:    punit_txt = {"V", 16'h0000};
            4'h2:    punit_txt = {"C", 16'h0000};
            4'h5:    punit_txt = "ppm";
            default: punit_txt = 24'h000000;
        endcase
    endfunction

    // Text words that the body picks one character from
    wire [15:0] lvl_w  = `SDICR_LEVEL_TXT;
    wire [31:0] pid_w  = pid_txt(pidx_r);
    wire [23:0] unit_w = punit_txt(pidx_r);

    assign tx_valid   = tx_valid_r;
    assign tx_data    = tx_data_r;
    assign addr_store = nv_wr_r;
    assign cur_addr   = addr_r;
    assign meas_start = mstart_r;
    assign meas_busy  = busy_r;
    assign val_hist   = (job_r == J_DATA) ? 4'h0 : hist_r;
    assign val_idx    = j_r[5:3];
    assign val_pos    = j_r[2:0];
    assign ivl_min    = ivl_r;
    assign sched_en   = sched_r;

    // Digits of a written setting, up to three
    always @* begin
        xval = 10'h000;
        xok  = (len_r > 4'h4) && (len_r < 4'h8);
        for (k = 4; k < 7; k = k + 1) begin
            if (k < len_r) begin
                xok  = xok && (cb[k] >= "0") && (cb[k] <= "9");
                xval = xval * 10'h00A + {2'b00, cb[k] - `SDICR_CH_ZERO};
            end
        end
    end

    // Body character at position j_r, zero bytes are skipped
    always @* begin
        bch  = 8'h00;
        blen = 7'h00;
        case (job_r)
            J_IDENT: begin
                blen = 7'h1D;
                if (j_r < 7'h02) begin
                    bch = j_r[0] ? lvl_w[7:0] : lvl_w[15:8];
                end else if (j_r < 7'h0A) begin
                    bch = VENDOR_TXT[8 * (7'h09 - j_r) +: 8];
                end else if (j_r < 7'h10) begin
                    bch = MODEL_TXT[8 * (7'h0F - j_r) +: 8];
                end else begin
                    bch = serial_txt[8 * (7'h1C - j_r) +: 8];
                end
            end
            J_MTIME: begin
                blen = two_r ? 7'h05 : 7'h04;
                case (j_r[2:0])
                    3'h0:    bch = d2;
                    3'h1:    bch = d1;
                    3'h2:    bch = d0;
                    3'h3:    bch = two_r ? `SDICR_CH_ZERO
                                         : `SDICR_CH_ZERO + {4'h0, `SDICR_NUM_VALUES};
                    default: bch = `SDICR_CH_ZERO + {4'h0, `SDICR_NUM_VALUES};
                endcase
            end
            J_DATA, J_HIST: begin
                blen = (job_r == J_DATA) ? {`SDICR_NUM_VALUES, 3'h0}
                                         : {`SDICR_HIST_VALUES, 3'h0};
                if (nan) begin
                    case (j_r[2:0])
                        3'h0:    bch = "+";
                        3'h1:    bch = "N";
                        3'h2:    bch = "a";
                        3'h3:    bch = "N";
                        default: bch = 8'h00;
                    endcase
                end else begin
                    bch = val_char;
                end
            end
            J_PARM: begin
                blen = 7'h0A;
                if (j_r == 7'h00 || j_r == 7'h05) begin
                    bch = ",";
                end else if (j_r < 7'h05) begin
                    bch = pid_w[8 * (7'h04 - j_r) +: 8];
                end else if (j_r < 7'h09) begin
                    bch = unit_w[8 * (7'h08 - j_r) +: 8];
                end else begin
                    bch = ";";
                end
            end
            J_SETV: begin
                blen = ssel_r ? 7'h01 : 7'h03;
                bch  = ssel_r ? d0 : (j_r == 7'h00) ? d2 : (j_r == 7'h01) ? d1 : d0;
            end
            J_CLOCK: begin
                blen = 7'h13;
                if (j_r == 7'h04 || j_r == 7'h07) begin
                    bch = "-";
                end else if (j_r == 7'h0A) begin
                    bch = " ";
                end else if (j_r == 7'h0D || j_r == 7'h10) begin
                    bch = ":";
                end else begin
                    bch = `SDICR_CH_ZERO + {4'h0, rtc_bcd[4 * (13 - cki) +: 4]};
                end
            end
            J_FW: begin
                blen = 7'h10;
                bch  = FW_TXT[8 * (7'h0F - j_r) +: 8];
            end
            default: begin
                blen = 7'h00;
                bch  = 8'h00;
            end
        endcase
    end

    // Command collection up to the terminating character
    always @(posedge core_clk) begin
        if (rst) begin
            len_r <= 4'h0;
        end else if (st_r != S_IDLE || go) begin
            len_r <= 4'h0;
        end else if (rx_valid) begin
            if (len_r < 4'h8) begin
                cb[len_r[2:0]] <= rx_data;
            end
            if (len_r != 4'hF) begin
                len_r <= len_r + 4'h1;
            end
        end
    end

    // Decode, schedule, measurement control and reply streaming
    always @(posedge core_clk) begin
        if (rst) begin
            st_r       <= S_IDLE;
            job_r      <= J_NONE;
            j_r        <= 7'h00;
            crc_on_r   <= 1'b0;
            two_r      <= 1'b0;
            hist_r     <= 4'h0;
            pidx_r     <= 4'h0;
            ssel_r     <= 1'b0;
            crc_r      <= `SDICR_CRC_INIT;
            crci_r     <= 2'h0;
            tx_data_r  <= 8'h00;
            tx_valid_r <= 1'b0;
            addr_r     <= `SDICR_ADDR_RST;
            boot_r     <= 1'b0;
            nv_wr_r    <= 1'b0;
            ivl_r      <= `SDICR_IVL_RST;
            sched_r    <= `SDICR_SCHED_RST;
            sec_cnt_r  <= 16'h0000;
            min_cnt_r  <= 10'h000;
            mstart_r   <= 1'b0;
            busy_r     <= 1'b0;
            srq_arm_r  <= 1'b0;
            srq_pend_r <= 1'b0;
            mcrc_r     <= 1'b0;
        end else begin
            nv_wr_r  <= 1'b0;
            mstart_r <= 1'b0;
            if (!boot_r) begin
                addr_r <= boot_addr;
                boot_r <= 1'b1;
            end
            // Reading schedule counted in seconds
            if (sched_r && sec_tick) begin
                if (sec_cnt_r >= {6'h00, ivl_r} * `SDICR_SEC_PER_MIN - 16'h0001) begin
                    sec_cnt_r <= 16'h0000;
                    if (!busy_r) begin
                        mstart_r <= 1'b1;
                        busy_r   <= 1'b1;
                    end
                end else begin
                    sec_cnt_r <= sec_cnt_r + 16'h0001;
                end
            end
            if (busy_r && meas_done) begin
                busy_r <= 1'b0;
                if (srq_arm_r) begin
                    srq_pend_r <= 1'b1;
                    srq_arm_r  <= 1'b0;
                end
            end
            if (tx_valid_r && tx_ready) begin
                tx_valid_r <= 1'b0;
            end
            case (st_r)
                S_IDLE: begin
                    crc_r    <= `SDICR_CRC_INIT;
                    j_r      <= 7'h00;
                    crc_on_r <= 1'b0;
                    job_r    <= J_NONE;
                    if (go && len_r == 4'h1 && cb[0] == `SDICR_CH_QUERY) begin
                        st_r <= S_ADDR;
                    end else if (go && own && len_r < 4'h9) begin
                        st_r <= S_ADDR;
                        if (cb[1] == "I" && len_r == 4'h2) begin
                            job_r <= J_IDENT;
                        end else if (cb[1] == "A" && len_r == 4'h3) begin
                            addr_r  <= cb[2];
                            nv_wr_r <= 1'b1;
                        end else if ((cb[1] == "M" || cb[1] == "C") &&
                                     (len_r == 4'h2 || (len_r == 4'h3 && cb[2] == "C"))) begin
                            job_r     <= J_MTIME;
                            two_r     <= (cb[1] == "C");
                            mcrc_r    <= (len_r == 4'h3);
                            srq_arm_r <= (cb[1] == "M");
                            mstart_r  <= 1'b1;
                            busy_r    <= 1'b1;
                        end else if (cb[1] == "D" && len_r == 4'h3) begin
                            job_r    <= (cb[2] == "0") ? J_DATA : J_NONE;
                            crc_on_r <= mcrc_r;
                        end else if (cb[1] == "R" && (len_r == 4'h3 ||
                                     (len_r == 4'h4 && cb[2] == "C"))) begin
                            job_r    <= J_HIST;
                            crc_on_r <= (len_r == 4'h4);
                            hist_r   <= (len_r == 4'h4) ? cb[3][3:0] : cb[2][3:0];
                        end else if (cb[1] == "I" && (cb[2] == "M" || cb[2] == "C")) begin
                            two_r <= (cb[2] == "C");
                            if (len_r == pp) begin
                                job_r <= J_MTIME;
                            end else if (len_r == pp + 4'h4 && cb[pp[2:0]] == "_" &&
                                         pch >= "1" && pch <= "6") begin
                                job_r    <= J_PARM;
                                crc_on_r <= c3;
                                pidx_r   <= pch[3:0];
                            end
                        end else if (cb[1] == "X" && cb[2] == "G" && len_r == 4'h4) begin
                            job_r  <= (cb[3] == "r" || cb[3] == "u") ? J_SETV : J_NONE;
                            ssel_r <= (cb[3] == "u");
                        end else if (cb[1] == "X" && cb[2] == "S" &&
                                     (cb[3] == "r" || cb[3] == "u")) begin
                            job_r  <= J_SETV;
                            ssel_r <= (cb[3] == "u");
                            if (xok && cb[3] == "r" && xval >= `SDICR_IVL_MIN &&
                                xval <= `SDICR_IVL_MAX) begin
                                ivl_r     <= xval;
                                sec_cnt_r <= 16'h0000;
                            end
                            if (xok && cb[3] == "u" && xval < 10'h002) begin
                                sched_r <= xval[0];
                            end
                        end else if (cb[1] == "X" && len_r == 4'h3) begin
                            job_r <= (cb[2] == "c") ? J_CLOCK :
                                     (cb[2] == "v") ? J_FW : J_NONE;
                        end
                    end else if (srq_pend_r && !go) begin
                        // A request landing in this cycle stays pending
                        srq_pend_r <= busy_r && meas_done && srq_arm_r;
                        st_r       <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    if (can_ld) begin
                        tx_data_r  <= addr_r;
                        tx_valid_r <= 1'b1;
                        crc_r      <= crc_nx;
                        st_r       <= S_BODY;
                    end
                end
                S_BODY: begin
                    if (can_ld) begin
                        if (j_r >= blen) begin
                            st_r   <= crc_on_r ? S_CRC : S_CR;
                            crci_r <= 2'h0;
                        end else begin
                            j_r <= j_r + 7'h01;
                            if (bch != 8'h00) begin
                                tx_data_r  <= bch;
                                tx_valid_r <= 1'b1;
                                crc_r      <= crc_nx;
                            end
                        end
                    end
                end
                S_CRC: begin
                    if (can_ld) begin
                        tx_valid_r <= 1'b1;
                        crci_r     <= crci_r + 2'h1;
                        case (crci_r)
                            2'h0:    tx_data_r <= `SDICR_CRC_CHAR | {4'h0, crc_r[15:12]};
                            2'h1:    tx_data_r <= `SDICR_CRC_CHAR | {2'h0, crc_r[11:6]};
                            default: tx_data_r <= `SDICR_CRC_CHAR | {2'h0, crc_r[5:0]};
                        endcase
                        if (crci_r == 2'h2) begin
                            st_r <= S_CR;
                        end
                    end
                end
                S_CR: begin
                    if (can_ld) begin
                        tx_data_r  <= `SDICR_CH_CR;
                        tx_valid_r <= 1'b1;
                        st_r       <= S_LF;
                    end
                end
                S_LF: begin
                    if (can_ld) begin
                        tx_data_r  <= `SDICR_CH_LF;
                        tx_valid_r <= 1'b1;
                        st_r       <= S_IDLE;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// file: verification/sdicr_props.sv
// Port checker for the command responder.
// Bound to sdicr_top; watches its ports only.
`timescale 1ns/100ps
module sdicr_props (
    input wire       core_clk,   // Clock
    input wire       rst,        // Reset
    input wire       rx_valid,   // Command strobe
    input wire [7:0] rx_data,    // Command byte
    input wire       tx_valid,   // Reply valid
    input wire [7:0] tx_data,    // Reply byte
    input wire       tx_ready,   // Reply taken
    input wire       addr_store, // Store pulse
    input wire [7:0] cur_addr,   // Address
    input wire       meas_start, // Start pulse
    input wire       meas_busy,  // Running
    input wire [9:0] ivl_min     // Interval
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Reply protocol and pulse shapes
    a_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before taken");
    a_cr_then_lf: assert property (tx_valid && tx_ready && tx_data == 8'h0D |=>
        tx_valid && tx_data == 8'h0A) else $error("line feed missing");
    a_query_reply: assert property (!tx_valid && rx_valid && rx_data == 8'h3F ##1
        rx_valid && rx_data == 8'h21 |-> ##2 tx_valid && tx_data == cur_addr)
        else $error("query not answered");
    a_ack_reply: assert property (!tx_valid && rx_valid && rx_data == cur_addr ##1
        rx_valid && rx_data == 8'h21 |-> ##2 tx_valid && tx_data == cur_addr)
        else $error("acknowledge not answered");
    a_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("start longer than one cycle");
    a_start_busy: assert property (meas_start |=> meas_busy)
        else $error("busy not raised");
    a_store_pulse: assert property (addr_store |=> !addr_store)
        else $error("store longer than one cycle");
    a_ivl_range: assert property (ivl_min >= 10'h001 && ivl_min <= 10'h2D0)
        else $error("interval out of range");
    c_start: cover property (meas_start);
    c_store: cover property (addr_store);
    c_stall: cover property (tx_valid && !tx_ready);
endmodule

// file: verification/sdicr_rec.sv
// Recorder model: sends command bytes and collects reply bytes.
// Drives on the falling edge; one command at a time.
`timescale 1ns/100ps
module sdicr_rec (
    input  wire        core_clk, // Clock
    input  wire        tx_valid, // Reply valid
    input  wire [7:0]  tx_data,  // Reply byte
    output logic       tx_ready, // Reply taken
    output logic       rx_valid, // Command strobe
    output logic [7:0] rx_data   // Command byte
);
    string rsp = "";
    bit    slow = 1'b0;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // Takes reply bytes, stalling every other cycle when slow
    always @(negedge core_clk) tx_ready <= !slow || !tx_ready;
    always @(posedge core_clk) if (tx_valid && tx_ready) rsp = $sformatf("%s%c", rsp, tx_data);
    // Sends a command whole, then leaves the data line inverted
    task send(input string c);
        rsp = "";
        for (int i = 0; i < c.len(); i++) begin
            @(negedge core_clk);
            rx_valid = 1'b1;
            rx_data = c[i];
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

// file: verification/sdicr_top_tb.sv
// Testbench: recorder model, history store, clock and ticks.
// Runs the scenarios in order on one responder.
`timescale 1ns/100ps
module sdicr_top_tb;
    logic         core_clk = 1'b0, rst = 1'b1, sec_tick = 1'b0, meas_done = 1'b0;
    logic         rx_valid, tx_valid, tx_ready, addr_store, meas_start, meas_busy, sched_en;
    logic [7:0]   rx_data, tx_data, cur_addr, val_char, boot_addr = 8'h35;
    logic [3:0]   hist_count = 4'h2, val_hist;
    logic [2:0]   val_idx, val_pos;
    logic [9:0]   ivl_min;
    logic [103:0] serial_txt = "1234567890123";
    logic [55:0]  rtc_bcd = 56'h20240102030405;
    int           miscompares = 0, checked = 0, starts = 0;
    sdicr_top u_dut (.*);
    sdicr_rec u_rec (.*);
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (meas_start) starts++;
    // History store: each value is a sign and one digit
    assign val_char = (val_pos == 3'h0) ? 8'h2B :
                      (val_pos == 3'h1) ? 8'h30 + val_idx + val_hist : 8'h00;
    task test_done;
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string got, input string exp);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("[FAIL] %0t got %s want %s", $time, got, exp);
        end
    endtask
    // Sends a command, waits a bounded time for the line feed, compares
    task cmd(input string c, input string exp);
        u_rec.send(c);
        repeat (300) if (u_rec.rsp.len() == 0 || u_rec.rsp[u_rec.rsp.len() - 1] != 8'h0A)
            @(negedge core_clk);
        chk(u_rec.rsp, exp.len() ? {exp, "\015\012"} : "");
    endtask
    task done;
        @(negedge core_clk) meas_done = 1'b1;
        @(negedge core_clk) meas_done = 1'b0;
    endtask
    function automatic string crc(input string s);
        logic [15:0] c = 16'h0000;
        for (int i = 0; i < s.len(); i++) begin
            c = c ^ s[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return $sformatf("%c%c%c", 8'h40 | c[15:12], 8'h40 | c[11:6], 8'h40 | c[5:0]);
    endfunction
    task t_basic;
        cmd("?!", "5");
        cmd("5!", "5");
        cmd("3!", "");
        cmd("5I!", "514VENDOR01MODEL11234567890123");
    endtask
    task t_meas;
        cmd("5M!", "50206");
        done;
        cmd("", "5");
        cmd("5D0!", "5+0+1+2+3+4+5");
        cmd("5D1!", "5");
        cmd("5C!", "502006");
        done;
        cmd("", "");
        cmd("5IM!", "50206");
        chk($sformatf("%0d", starts), "2");
    endtask
    task t_cont;
        u_rec.slow = 1'b1;
        cmd("5R1!", "5+1+2+3+4+5+6+7+8");
        cmd("5R2!", {"5", {8{"+NaN"}}});
        cmd("5RC0!", {"5+0+1+2+3+4+5+6+7", crc("5+0+1+2+3+4+5+6+7")});
        cmd("5CC!", "502006");
        done;
        cmd("5D0!", {"5+0+1+2+3+4+5", crc("5+0+1+2+3+4+5")});
        cmd("5ICC!", "502006");
        cmd("5IM_001!", "5,VBAT,V;");
        cmd("5IMC_005!", {"5,PPM,ppm;", crc("5,PPM,ppm;")});
        u_rec.slow = 1'b0;
    endtask
    task t_set;
        cmd("5XSr721!", "5060");
        cmd("5XSr1!", "5001");
        cmd("5XGr!", "5001");
        repeat (120) @(negedge core_clk) sec_tick = ~sec_tick;
        repeat (4) @(negedge core_clk);
        chk($sformatf("%0d", starts), "4");
        done;
        cmd("5XSu0!", "50");
        cmd("5XGu!", "50");
        chk($sformatf("%0d %0d", ivl_min, sched_en), "1 0");
        repeat (120) @(negedge core_clk) sec_tick = ~sec_tick;
        chk($sformatf("%0d", starts), "4");
    endtask
    task t_misc;
        cmd("5Xc!", "52024-01-02 03:04:05");
        cmd("5Xv!", "51.0.0-0-g0000000");
        cmd("5A7!", "7");
        cmd("7!", "7");
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        t_basic;
        t_meas;
        t_cont;
        t_set;
        t_misc;
        test_done;
    end
    // Watchdog against a hung reply
    initial begin
        #100000;
        miscompares++;
        test_done;
    end
endmodule
bind sdicr_top sdicr_props u_props (.*);
